// ### rsw_top.sv
// Reset sources, reset status, reset state values and watchdog.
// Assumes CPU bus strobes on ref_clk; pins and cause inputs are asynchronous.
`timescale 1ns/1ps
`include "rsw_params.svh"

module rsw_top
  import rsw_pkg::*;
#(
  parameter int LPO_DIV = `RSW_LPO_DIV,
  parameter int HOLD    = 4
)
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              por_req,
  input  wire logic              pin_reset_n,
  input  wire logic              lvd_req,
  input  wire logic              illegal_opcode_reset_req,
  input  wire logic              dbg_reset_req,
  input  wire logic              bus_valid,
  input  wire logic              bus_write,
  input  wire logic              bus_unimpl,
  input  wire logic              srs_sel,
  input  wire logic              opt1_sel,
  input  wire logic              opt2_sel,
  input  wire logic [7:0]        bus_wdata,
  input  wire logic              bdm_active,
  input  wire logic              stop_active,
  output logic                   sys_reset,
  output logic [7:0]             reset_status_reg,
  output logic [1:0]             wdog_timeout_sel,
  output logic                   wdog_clock_sel,
  output logic                   wdog_window_en,
  output logic                   vec_fetch,
  output logic [15:0]            vec_addr,
  output logic                   pc_load_hi,
  output logic                   pc_load_lo,
  output logic                   periph_disable,
  output logic                   pin_dir_in,
  output logic                   pin_pullup_off,
  output logic                   ccr_imask_set,
  output logic                   sp_load,
  output logic [15:0]            sp_value
);

  // ****************************************
  // Parameter checks
  // ****************************************
  initial begin
    if (HOLD < 1 || HOLD > 255) $error("rsw_top: HOLD out of range");
    if (LPO_DIV < 2) $error("rsw_top: LPO_DIV too small");
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic por_s, pin_n_s, lvd_s, illegal_opcode_reset_s, dbg_s, bdm_s, stop_s;
  logic [6:0] raw_in, syn_out;

  assign raw_in = {por_req, pin_reset_n, lvd_req, illegal_opcode_reset_req, dbg_reset_req,
                   bdm_active, stop_active};
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_sync
      rsw_sync u_sync (
        .ref_clk (ref_clk),
        .rst     (1'b0),
        .din     (raw_in[gi]),
        .dout    (syn_out[gi])
      );
    end
  endgenerate
  assign {por_s, pin_n_s, lvd_s, illegal_opcode_reset_s, dbg_s, bdm_s, stop_s} = syn_out;

  // ****************************************
  // Watchdog configuration with write-once lock
  // ****************************************
  logic opt1_done_q, opt2_done_q;
  logic wr_opt1, wr_opt2, wr_srs;
  logic wd_init;

  assign wr_opt1 = bus_valid && bus_write && opt1_sel && !sys_reset;
  assign wr_opt2 = bus_valid && bus_write && opt2_sel && !sys_reset;
  assign wr_srs  = bus_valid && bus_write && srs_sel && !sys_reset;
  assign wd_init = (wr_opt1 && !opt1_done_q) || (wr_opt2 && !opt2_done_q);

  always_ff @(posedge ref_clk) begin
    if (rst || sys_reset) begin
      opt1_done_q      <= 1'b0;
      opt2_done_q      <= 1'b0;
      wdog_timeout_sel <= `RSW_TSEL_RESET;
      wdog_clock_sel   <= `RSW_CSEL_RESET;
      wdog_window_en   <= `RSW_WIN_RESET;
    end else begin
      if (wr_opt1 && !opt1_done_q) begin
        opt1_done_q      <= 1'b1;
        wdog_timeout_sel <= bus_wdata[7:6];
      end
      if (wr_opt2 && !opt2_done_q) begin
        opt2_done_q    <= 1'b1;
        wdog_clock_sel <= bus_wdata[7];
        wdog_window_en <= bus_wdata[1];
      end
    end
  end

  // ****************************************
  // Overflow and window limits
  // ****************************************
  // One bit wider than the counter, so the 2^18 limit fits exactly
  function automatic logic [18:0] ovf_limit(input logic [1:0] tsel, input logic csel);
    unique case ({csel, tsel})
      3'b001:  ovf_limit = `RSW_LP_OVF1;
      3'b010:  ovf_limit = `RSW_LP_OVF2;
      3'b011:  ovf_limit = `RSW_LP_OVF3;
      3'b101:  ovf_limit = `RSW_BUS_OVF1;
      3'b110:  ovf_limit = `RSW_BUS_OVF2;
      3'b111:  ovf_limit = `RSW_BUS_OVF3;
      default: ovf_limit = 19'h7FFFF;
    endcase
  endfunction

  function automatic logic [17:0] win_limit(input logic [1:0] tsel);
    unique case (tsel)
      2'b01:   win_limit = `RSW_WIN1;
      2'b10:   win_limit = `RSW_WIN2;
      2'b11:   win_limit = `RSW_WIN3;
      default: win_limit = 18'h0;
    endcase
  endfunction

  // ****************************************
  // Count clock selection
  // ****************************************
  logic wd_en, halted, halted_q, lp_tick, cnt_tick;

  assign wd_en  = (wdog_timeout_sel != 2'h0);
  assign halted = bdm_s || stop_s;

  always_ff @(posedge ref_clk) begin
    if (rst) halted_q <= 1'b0;
    else     halted_q <= halted;
  end

  rsw_lpo #(.DIV(LPO_DIV)) u_lpo (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clr     (halted),
    .tick    (lp_tick)
  );

  assign cnt_tick = !halted && (wdog_clock_sel ? 1'b1 : lp_tick);

  // ****************************************
  // Service key sequence
  // ****************************************
  rsw_seq_t seq_q;
  logic     key1, key2, bad_key, serviced, early, wd_win;
  logic [17:0] cnt_q;

  assign key1     = wr_srs && (bus_wdata == `RSW_KEY_FIRST);
  assign key2     = wr_srs && (bus_wdata == `RSW_KEY_SECOND);
  assign bad_key  = wr_srs && !key1 && !key2;
  assign serviced = key2 && (seq_q == RSW_SEQ_ARMED);
  assign wd_win   = wdog_window_en && wdog_clock_sel;
  assign early    = wd_en && wd_win && (key1 || key2) &&
                    (cnt_q < win_limit(wdog_timeout_sel));

  always_ff @(posedge ref_clk) begin
    if (rst || sys_reset) begin
      seq_q <= RSW_SEQ_IDLE;
    end else if (key1) begin
      seq_q <= RSW_SEQ_ARMED;
    end else if (key2) begin
      seq_q <= RSW_SEQ_IDLE;
    end
  end

  // ****************************************
  // Watchdog counter
  // ****************************************
  logic timeout;

  assign timeout = wd_en && cnt_tick &&
                   ({1'b0, cnt_q} + 19'h1 >= ovf_limit(wdog_timeout_sel, wdog_clock_sel));

  always_ff @(posedge ref_clk) begin
    if (rst || sys_reset || wd_init || serviced) begin
      cnt_q <= 18'h0;
    end else if (!wdog_clock_sel && halted && !halted_q) begin
      cnt_q <= 18'h0;
    end else if (wd_en && cnt_tick) begin
      cnt_q <= cnt_q + 18'h1;
    end
  end

  // ****************************************
  // Reset cause gathering and status
  // ****************************************
  logic wdog_rst, illegal_address_reset_rst, any_cause;
  logic [7:0] cause;

  assign wdog_rst = timeout || bad_key || early;
  assign illegal_address_reset_rst = bus_valid && bus_unimpl && !sys_reset;
  assign cause    = por_s    ? 8'h80 :
                    !pin_n_s ? 8'h40 :
                    lvd_s    ? 8'h02 :
                    wdog_rst ? 8'h20 :
                    illegal_opcode_reset_s   ? 8'h10 :
                    illegal_address_reset_rst ? 8'h08 : 8'h00;
  assign any_cause = (cause != 8'h00) || dbg_s;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reset_status_reg <= 8'h80;
    end else if (any_cause && !sys_reset) begin
      reset_status_reg <= cause;
    end
  end

  // ****************************************
  // Reset sequencing and vector fetch
  // ****************************************
  rsw_rst_t st_q;
  logic [7:0] hold_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q   <= RSW_HOLD;
      hold_q <= 8'(HOLD);
    end else begin
      unique case (st_q)
        RSW_RUN: begin
          if (any_cause) begin
            st_q   <= RSW_HOLD;
            hold_q <= 8'(HOLD);
          end
        end
        RSW_HOLD: begin
          if (any_cause || (!pin_n_s) || por_s) begin
            hold_q <= 8'(HOLD);
          end else if (hold_q == 8'h1) begin
            st_q <= RSW_VEC_HI;
          end else begin
            hold_q <= hold_q - 8'h1;
          end
        end
        RSW_VEC_HI: st_q <= RSW_VEC_LO;
        RSW_VEC_LO: st_q <= RSW_RUN;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      vec_addr <= 16'h0;
      // Valid already while sp_load is high in reset
      sp_value <= `RSW_SP_RESET;
    end else begin
      vec_addr <= (st_q == RSW_VEC_HI) ? `RSW_RESET_VECTOR_HI : `RSW_RESET_VECTOR_LO;
      sp_value <= `RSW_SP_RESET;
    end
  end

  assign sys_reset      = (st_q == RSW_HOLD);
  assign periph_disable = sys_reset;
  assign pin_dir_in     = sys_reset;
  assign pin_pullup_off = sys_reset;
  assign ccr_imask_set  = sys_reset;
  assign sp_load        = sys_reset;
  assign vec_fetch      = (st_q == RSW_VEC_HI) || (st_q == RSW_VEC_LO);
  assign pc_load_hi     = (st_q == RSW_VEC_HI);
  assign pc_load_lo     = (st_q == RSW_VEC_LO);

endmodule

// ### rsw_params.svh
// Constants for the reset source and watchdog block.
// Assumes inclusion by bare name from the package and modules.
`ifndef RSW_PARAMS_SVH
`define RSW_PARAMS_SVH

// ****************************************
// Reset state values
// ****************************************
`define RSW_RESET_VECTOR_HI   16'hFFFE
`define RSW_RESET_VECTOR_LO   16'hFFFF
`define RSW_SP_RESET          16'h00FF

// ****************************************
// Service keys
// ****************************************
`define RSW_KEY_FIRST         8'h55
`define RSW_KEY_SECOND        8'hAA

// ****************************************
// Status bit positions
// ****************************************
`define RSW_ST_LVD            1
`define RSW_ST_ILLEGAL_ADDRESS_RESET           3
`define RSW_ST_ILLEGAL_OPCODE_RESET           4
`define RSW_ST_WDOG           5
`define RSW_ST_PIN            6
`define RSW_ST_POR            7

// ****************************************
// Configuration defaults and timing
// ****************************************
`define RSW_TSEL_RESET        2'h3
`define RSW_CSEL_RESET        1'h0
`define RSW_WIN_RESET         1'h0
`define RSW_LPO_PERIOD_NS     1000000
`define RSW_CLK_PERIOD_NS     100
`define RSW_LPO_DIV           (`RSW_LPO_PERIOD_NS / `RSW_CLK_PERIOD_NS)
`define RSW_LP_OVF1           19'h00020
`define RSW_LP_OVF2           19'h00100
`define RSW_LP_OVF3           19'h00400
`define RSW_BUS_OVF1          19'h02000
`define RSW_BUS_OVF2          19'h10000
`define RSW_BUS_OVF3          19'h40000
`define RSW_WIN1              18'h01800
`define RSW_WIN2              18'h0C000
`define RSW_WIN3              18'h30000

`endif

// ### rsw_pkg.sv
// Types for the reset source and watchdog block.
// Assumes rsw_params.svh is on the include path.
package rsw_pkg;
  `include "rsw_params.svh"

  typedef enum logic [1:0] {
    RSW_SEQ_IDLE,
    RSW_SEQ_ARMED
  } rsw_seq_t;

  typedef enum logic [2:0] {
    RSW_RUN,
    RSW_HOLD,
    RSW_VEC_HI,
    RSW_VEC_LO
  } rsw_rst_t;
endpackage

// ### rsw_sync.sv
// Two-stage synchroniser for a level from outside the clock domain.
// Assumes the input is quasi-static relative to ref_clk.
`timescale 1ns/1ps
module rsw_sync
  import rsw_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// ### rsw_lpo.sv
// Low-power tick generator: one pulse per nominal 1 ms.
// Assumes ref_clk at the rate given in the params header.
`timescale 1ns/1ps
`include "rsw_params.svh"
module rsw_lpo
  import rsw_pkg::*;
#(
  parameter int DIV = `RSW_LPO_DIV
)
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic clr,
  output logic      tick
);
  logic [31:0] cnt_q;

  initial begin
    if (DIV < 2) $error("rsw_lpo: DIV too small");
  end

  always_ff @(posedge ref_clk) begin
    if (rst || clr) begin
      cnt_q <= 32'h0;
      tick  <= 1'b0;
    end else if (cnt_q == 32'(DIV - 1)) begin
      cnt_q <= 32'h0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick  <= 1'b0;
    end
  end
endmodule

// ### rsw_top_properties.sv
// Port checker for the reset source and watchdog block.
// Assumes it is bound to rsw_top and sees only its ports.
`timescale 1ns/1ps
module rsw_chk #(
  parameter int LPO_DIV = 4,
  parameter int HOLD    = 4
) (
  input logic        ref_clk,
  input logic        rst,
  input logic        bus_valid,
  input logic        bus_write,
  input logic        bus_unimpl,
  input logic        srs_sel,
  input logic        opt1_sel,
  input logic        opt2_sel,
  input logic [7:0]  bus_wdata,
  input logic        sys_reset,
  input logic [7:0]  reset_status_reg,
  input logic [1:0]  wdog_timeout_sel,
  input logic        wdog_clock_sel,
  input logic        wdog_window_en,
  input logic        pc_load_hi,
  input logic        pc_load_lo,
  input logic [15:0] vec_addr,
  input logic        periph_disable,
  input logic        pin_dir_in,
  input logic        pin_pullup_off,
  input logic        ccr_imask_set,
  input logic        sp_load,
  input logic [15:0] sp_value
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic lk1_q;
  logic lk2_q;
  logic take;
  assign take = bus_valid && bus_write && !sys_reset;
  // ****
  // Option register lock tracking
  // ****
  always_ff @(posedge ref_clk) begin
    if (rst || sys_reset) lk1_q <= 1'b0;
    else if (take && opt1_sel) lk1_q <= 1'b1;
  end
  always_ff @(posedge ref_clk) begin
    if (rst || sys_reset) lk2_q <= 1'b0;
    else if (take && opt2_sel) lk2_q <= 1'b1;
  end
  sequence wdog_rst_s;
    sys_reset ##[0:1] reset_status_reg == 8'h20;
  endsequence
  sequence vec_s;
    pc_load_lo && vec_addr == 16'hFFFE ##1 vec_addr == 16'hFFFF;
  endsequence
  AST_PIN_SAFE: assert property (sys_reset |-> periph_disable && pin_dir_in && pin_pullup_off)
    else $error("pins not safe in reset");
  AST_IMASK: assert property ($rose(sys_reset) |-> ccr_imask_set [*2])
    else $error("interrupt mask not set in reset");
  AST_SP_LOAD: assert property (sp_load |-> sp_value == 16'h00FF)
    else $error("stack pointer load value wrong");
  AST_VECTOR: assert property (pc_load_hi |=> vec_s)
    else $error("vector fetch order wrong");
  AST_BAD_KEY: assert property (take && srs_sel && !bus_unimpl && bus_wdata != 8'h55
    && bus_wdata != 8'hAA |-> ##[1:2] wdog_rst_s)
    else $error("bad key did not reset");
  AST_UNIMPL: assert property (bus_valid && bus_unimpl && !sys_reset
    |-> ##[1:2] sys_reset ##[0:1] reset_status_reg == 8'h08)
    else $error("unmapped access did not reset");
  AST_STATUS_RO: assert property ($changed(reset_status_reg) |-> sys_reset || $past(sys_reset))
    else $error("status changed outside reset");
  AST_LOCK1: assert property (lk1_q && $past(lk1_q, 2) && !sys_reset |-> $stable(wdog_timeout_sel))
    else $error("timeout select changed after lock");
  AST_LOCK2: assert property (lk2_q && $past(lk2_q, 2) && !sys_reset
    |-> $stable({wdog_clock_sel, wdog_window_en}))
    else $error("clock or window changed after lock");
  AST_DEFAULTS: assert property (!lk1_q && !lk2_q && !sys_reset
    |-> wdog_timeout_sel == 2'h3 && !wdog_clock_sel && !wdog_window_en)
    else $error("watchdog defaults wrong");
endmodule

bind rsw_top rsw_chk #(.LPO_DIV(LPO_DIV), .HOLD(HOLD)) u_chk (.*);

// ### rsw_cpu_model.sv
// CPU software model issuing one-cycle register write strobes.
// Assumes the block samples strobes on ref_clk rising edges.
`timescale 1ns/1ps
module rsw_cpu_model (
  input  logic       ref_clk,
  output logic       bus_valid,
  output logic       bus_write,
  output logic       bus_unimpl,
  output logic       srs_sel,
  output logic       opt1_sel,
  output logic       opt2_sel,
  output logic [7:0] bus_wdata
);
  initial begin
    {bus_valid, bus_write, srs_sel, opt1_sel, opt2_sel, bus_unimpl} = 6'h00;
    bus_wdata = 8'h00;
  end
  // ****
  // Write: 0 status, 1 option 1, 2 option 2, 3 unmapped
  // ****
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(posedge ref_clk);
    {bus_valid, bus_write} <= 2'h3;
    {srs_sel, opt1_sel, opt2_sel, bus_unimpl} <= 4'h8 >> s;
    bus_wdata <= d;
    @(posedge ref_clk);
    {bus_valid, bus_write, srs_sel, opt1_sel, opt2_sel, bus_unimpl} <= 6'h00;
    bus_wdata <= ~d;
  endtask
  task automatic service();
    wr(2'd0, 8'h55);
    wr(2'd0, 8'hAA);
  endtask
endmodule

// ### tb_top.sv
// Self-checking bench for rsw_top driven by the CPU model.
// Assumes the package, design, model and checker are compiled first.
`timescale 1ns/1ps
module tb_top;
  logic        ref_clk, rst, por_req, pin_reset_n, lvd_req, illegal_opcode_reset_req;
  logic        dbg_reset_req, bdm_active, stop_active, sys_reset;
  logic        bus_valid, bus_write, bus_unimpl, srs_sel, opt1_sel, opt2_sel;
  logic        wdog_clock_sel, wdog_window_en, vec_fetch, pc_load_hi, pc_load_lo;
  logic        periph_disable, pin_dir_in, pin_pullup_off, ccr_imask_set, sp_load;
  logic [1:0]  wdog_timeout_sel;
  logic [7:0]  bus_wdata, reset_status_reg;
  logic [15:0] vec_addr, sp_value;
  logic        prev_r;
  int          failures, check_count, rises, n, r0, vecs;
  logic [7:0]  exp_st [7] = '{8'h80, 8'h40, 8'h02, 8'h10, 8'h00, 8'h08, 8'h20};

  rsw_top #(.LPO_DIV(4), .HOLD(4)) u_dut (.*);
  rsw_cpu_model u_cpu (.*);

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (sys_reset === 1'b1 && prev_r !== 1'b1) rises++;
    if (vec_fetch === 1'b1) vecs++;
    prev_r = sys_reset;
  end
  // ****
  // Helpers
  // ****
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic near(input string name, input int seen, input int exp);
    check(name, seen >= exp - 12 && seen <= exp + 12, 1'b1);
  endtask
  task automatic till_rst(input int lim, output int k);
    k = 0;
    while (sys_reset !== 1'b1 && k < lim) begin
      @(posedge ref_clk);
      k++;
    end
  endtask
  task automatic till_run();
    while (sys_reset !== 1'b0) @(posedge ref_clk);
    cyc(4);
  endtask
  task automatic kick();
    u_cpu.wr(2'd0, 8'h00);
    till_rst(20, n);
    till_run();
  endtask
  task automatic cause(input int i, input logic on);
    por_req <= on && i == 0;
    pin_reset_n <= !(on && i == 1);
    lvd_req <= on && i == 2;
    illegal_opcode_reset_req <= on && i == 3;
    dbg_reset_req <= on && i == 4;
    if (on && i == 5) u_cpu.wr(2'd3, 8'h00);
    if (on && i == 6) u_cpu.wr(2'd0, 8'h12);
  endtask
  task automatic cfg(input logic [7:0] o1, input logic [7:0] o2);
    u_cpu.wr(2'd1, o1);
    u_cpu.wr(2'd2, o2);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    failures++;
    wrap_up();
  end
  // ****
  // Scenarios
  // ****
  initial begin
    {rst, por_req, lvd_req, illegal_opcode_reset_req, dbg_reset_req, bdm_active, stop_active} = 7'h40;
    pin_reset_n = 1'b1;
    cyc(3);
    rst <= 1'b0;
    till_run();
    check("status after reset", reset_status_reg, 8'h80);
    check("tsel default", wdog_timeout_sel, 2'h3);
    check("csel default", wdog_clock_sel, 1'b0);
    check("sp value", sp_value, 16'h00FF);
    till_rst(6000, n);
    near("lp 2^10 timeout", n, 4096);
    check("timeout status", reset_status_reg, 8'h20);
    till_run();
    cfg(8'h40, 8'h00);
    cfg(8'h00, 8'h82);
    check("tsel locked", wdog_timeout_sel, 2'h1);
    check("csel locked", wdog_clock_sel, 1'b0);
    check("win locked", wdog_window_en, 1'b0);
    r0 = rises;
    repeat (4) begin
      cyc(80);
      u_cpu.service();
    end
    check("serviced", rises, r0);
    check("status kept", reset_status_reg, 8'h20);
    cyc(60);
    u_cpu.wr(2'd0, 8'hAA);
    till_rst(300, n);
    near("lp 2^5 timeout", n + 62, 128);
    till_run();
    for (int i = 0; i < 7; i++) begin
      cause(i, 1'b1);
      till_rst(20, n);
      cause(i, 1'b0);
      till_run();
      check("cause status", reset_status_reg, exp_st[i]);
    end
    u_cpu.wr(2'd1, 8'h00);
    r0 = rises;
    cyc(4600);
    check("disabled", rises, r0);
    kick();
    cfg(8'h40, 8'h02);
    r0 = rises;
    u_cpu.service();
    cyc(20);
    check("lp window off", rises, r0);
    kick();
    cfg(8'h40, 8'h82);
    cyc(6120);
    u_cpu.wr(2'd0, 8'h55);
    till_rst(4, n);
    check("early key", sys_reset, 1'b1);
    till_run();
    check("early status", reset_status_reg, 8'h20);
    cfg(8'h40, 8'h82);
    r0 = rises;
    cyc(6170);
    u_cpu.service();
    check("in window", rises, r0);
    till_rst(9000, n);
    near("bus 2^13 timeout", n, 8192);
    till_run();
    cfg(8'h40, 8'h80);
    cyc(100);
    stop_active <= 1'b1;
    cyc(3000);
    stop_active <= 1'b0;
    till_rst(9000, n);
    near("bus hold in stop", n, 8092);
    till_run();
    check("vector cycles", vecs, 2 * rises);
    cfg(8'h40, 8'h00);
    cyc(100);
    bdm_active <= 1'b1;
    cyc(50);
    bdm_active <= 1'b0;
    till_rst(300, n);
    near("lp clear in debug", n, 128);
    wrap_up();
  end
endmodule
